// ==== acs_pkg.sv ====
// Purpose: shared constants and types of the converter sequencer
// Assumes: registers are word aligned, byte address = index * 4
// Notes: all offsets below are register indices
package acs_pkg;

  // register indices
  localparam logic [5:0] IDX_CONV_CTRL = 6'h00;
  localparam logic [5:0] IDX_ACC_CTRL = 6'h01;
  localparam logic [5:0] IDX_CLK_CTRL = 6'h02;
  localparam logic [5:0] IDX_TIMING = 6'h03;
  localparam logic [5:0] IDX_WINDOW = 6'h04;
  localparam logic [5:0] IDX_SAMPLE = 6'h05;
  localparam logic [5:0] IDX_CHANNEL = 6'h06;
  localparam logic [5:0] IDX_COMMAND = 6'h08;
  localparam logic [5:0] IDX_EVENT = 6'h09;
  localparam logic [5:0] IDX_INT_EN = 6'h0a;
  localparam logic [5:0] IDX_FLAGS = 6'h0b;
  localparam logic [5:0] IDX_RESULT = 6'h10;
  localparam logic [5:0] IDX_LOW_THR = 6'h12;
  localparam logic [5:0] IDX_HIGH_THR = 6'h14;

  // field positions
  localparam int ENABLE_BIT = 0;
  localparam int CONTINUOUS_MODE_EN_BIT = 1;
  localparam int REF_LSB = 4;
  localparam int INIT_LSB = 5;
  localparam int VARY_BIT = 4;
  localparam int READY_BIT = 0;
  localparam int WINDOW_BIT = 1;
  localparam logic [1:0] REF_INTERNAL = 2'h0;

  // window modes
  localparam logic [2:0] WIN_NONE = 3'h0;
  localparam logic [2:0] WIN_BELOW = 3'h1;
  localparam logic [2:0] WIN_ABOVE = 3'h2;
  localparam logic [2:0] WIN_INSIDE = 3'h3;
  localparam logic [2:0] WIN_OUTSIDE = 3'h4;

  // channel codes
  localparam logic [4:0] CH_LAST_PIN = 5'h0b;
  localparam logic [4:0] CH_TOUCH = 5'h1b;
  localparam logic [4:0] CH_FIRST_DAC = 5'h1c;
  localparam logic [4:0] CH_INT_REF = 5'h1d;
  localparam logic [4:0] CH_GROUND = 5'h1f;

  // timing in converter clock ticks, last legal codes, bus responses
  localparam logic [8:0] BASE_SAMPLE_TICKS = 9'h002;
  localparam logic [2:0] INIT_LAST_CODE = 3'h5;
  localparam logic [2:0] ACC_LAST_CODE = 3'h6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } acs_axi_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } acs_axi_rsp_type;

  typedef enum logic [2:0] {PH_IDLE, PH_INIT, PH_SAMPLE, PH_CONV, PH_DELAY} acs_phase_type;

endpackage

// ==== acs_sequencer.sv ====
// Purpose: control of a successive-approximation converter with AXI4-Lite registers
// Assumes: analog core answers with a 10-bit code held stable at the end of conversion
// Notes: timing counts are in converter clock ticks made by the prescaler
// What this block does
// - init delay on enable or internal reference
// - init codes 0..5 give 0..256 ticks
// - init delay also after deep sleep wake
// - cap open inter-sample delay ticks between samples
// - auto variation increments delay after each sample
// - auto variation wraps delay 0xf to 0
// - window modes none, below, above, inside, outside
// - sampling two ticks plus extension field
// - channel change waits for conversion end
// - channel codes pins 0-11 and internal sources
// - start bit write starts one measurement
// - start bit reads one while busy
// - enabled event input starts a conversion
// - enables: window bit 1, ready bit 0
// - window flag set only at conversion end
// - ready flag set at every completion
// - flags clear by write one or result read
// - continuous mode restarts right after completion
// - accumulate 1 to 64 samples per result
// - converter clock divides by 2 to 256
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module acs_sequencer
  import acs_pkg::*;
#(
  parameter int CONV_TICKS = 10, // conversion ticks after sampling
  parameter int CONVERTER_INDEX = 1 // 0 or 1, decides code 0x1b
) (
  input wire logic clock, // system clock, 40 MHz
  input wire logic reset, // synchronous, active high
  input wire acs_axi_req_type axi_req, // AXI4-Lite master signals
  output acs_axi_rsp_type axi_rsp, // AXI4-Lite slave signals
  input wire logic start_event, // trigger event, asynchronous level
  input wire logic deep_sleep_wake, // high when woken to measure
  input wire logic [9:0] afe_data, // code from analog core
  output logic [4:0] afe_channel, // channel in use by the mux
  output logic afe_channel_ok, // channel code is a legal source
  output logic afe_sample_close, // sampling cap connected
  output logic afe_convert, // analog core converting
  output logic conversion_busy, // measurement under way
  output logic result_irq, // result ready request
  output logic window_irq // window match request
);

  typedef struct packed {
    acs_phase_type phase;
    logic [8:0] cnt;
    logic [7:0] clock_divider_sel_cnt;
    logic enable;
    logic continuous_mode_en;
    logic [2:0] acc_sel;
    logic [2:0] clock_divider_sel_sel;
    logic [1:0] ref_sel;
    logic [2:0] init_sel;
    logic vary_en;
    logic [3:0] delay;
    logic [2:0] win_mode;
    logic [4:0] sample_len;
    logic [4:0] channel_sel;
    logic [4:0] active_ch;
    logic event_en;
    logic [1:0] int_en;
    logic [1:0] flags;
    logic [15:0] result;
    logic [15:0] acc_sum;
    logic [6:0] samples_left;
    logic [15:0] low_thr;
    logic [15:0] high_thr;
    logic init_pending;
    logic ev_s1;
    logic ev_s2;
    logic ev_s3;
    logic wake_s1;
    logic wake_s2;
    logic wake_s3;
    logic [9:0] data_s1;
    logic [9:0] data_s2;
    logic aw_held;
    logic [5:0] aw_idx;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } acs_state_type;

  acs_state_type s_q;
  acs_state_type s_d;
  logic tick;
  logic done;
  logic sample_end;

  // last prescaler count for divide by 2 ** (sel + 1)
  function automatic logic [7:0] div_last(input logic [2:0] sel);
    logic [8:0] full;
    full = 9'h002 << sel;
    return 8'(full - 9'h001);
  endfunction

  // init delay ticks, reserved codes give none
  function automatic logic [8:0] init_ticks(input logic [2:0] sel);
    logic [8:0] t;
    t = 9'h000;
    if (sel != 3'h0 && sel <= INIT_LAST_CODE) begin
      t = 9'h008 << sel;
    end
    return t;
  endfunction

  // window test on the whole unsigned result
  function automatic logic win_match(input logic [2:0] mode, input logic [15:0] res,
                                     input logic [15:0] lo, input logic [15:0] hi);
    logic m;
    m = 1'b0;
    case (mode)
      WIN_BELOW: m = res < lo;
      WIN_ABOVE: m = res > hi;
      WIN_INSIDE: m = (res > lo) && (res < hi);
      WIN_OUTSIDE: m = (res < lo) || (res > hi);
      default: m = 1'b0;
    endcase
    return m;
  endfunction

  // legal mux sources
  function automatic logic channel_legal(input logic [4:0] ch);
    logic ok;
    ok = (ch <= CH_LAST_PIN) || (ch == CH_FIRST_DAC) || (ch == CH_INT_REF)
         || (ch == CH_GROUND) || (ch == CH_TOUCH && CONVERTER_INDEX == 1);
    return ok;
  endfunction

  // register read value of one index
  function automatic logic [31:0] read_word(input acs_state_type s, input logic [5:0] idx);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (idx)
      IDX_CONV_CTRL: w[1:0] = {s.continuous_mode_en, s.enable};
      IDX_ACC_CTRL: w[2:0] = s.acc_sel;
      IDX_CLK_CTRL: w[5:0] = {s.ref_sel, 1'b0, s.clock_divider_sel_sel};
      IDX_TIMING: w[7:0] = {s.init_sel, s.vary_en, s.delay};
      IDX_WINDOW: w[2:0] = s.win_mode;
      IDX_SAMPLE: w[4:0] = s.sample_len;
      IDX_CHANNEL: w[4:0] = s.channel_sel;
      IDX_COMMAND: w[0] = s.phase != PH_IDLE;
      IDX_EVENT: w[0] = s.event_en;
      IDX_INT_EN: w[1:0] = s.int_en;
      IDX_FLAGS: w[1:0] = s.flags;
      IDX_RESULT: w[15:0] = s.result;
      IDX_LOW_THR: w[15:0] = s.low_thr;
      IDX_HIGH_THR: w[15:0] = s.high_thr;
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  function automatic logic idx_mapped(input logic [5:0] idx);
    logic m;
    m = (idx <= IDX_CHANNEL) || (idx >= IDX_COMMAND && idx <= IDX_FLAGS)
        || idx == IDX_RESULT || idx == IDX_LOW_THR || idx == IDX_HIGH_THR;
    return m;
  endfunction

  // next state of the whole block
  always_comb begin
    logic do_write;
    logic [31:0] wd;
    logic [3:0] ws;
    logic cmd_start;
    logic ev_start;
    logic rd_result;
    logic [15:0] sum;
    logic begin_conv;
    s_d = s_q;
    do_write = 1'b0;
    wd = s_q.w_data;
    ws = s_q.w_strb;
    cmd_start = 1'b0;
    ev_start = 1'b0;
    rd_result = 1'b0;
    sum = 16'h0000;
    begin_conv = 1'b0;
    done = 1'b0;
    sample_end = 1'b0;
    // synchronisers for pins and the analog code
    s_d.ev_s1 = start_event;
    s_d.ev_s2 = s_q.ev_s1;
    s_d.ev_s3 = s_q.ev_s2;
    s_d.wake_s1 = deep_sleep_wake;
    s_d.wake_s2 = s_q.wake_s1;
    s_d.wake_s3 = s_q.wake_s2;
    s_d.data_s1 = afe_data;
    s_d.data_s2 = s_q.data_s1;
    // converter clock tick from the prescaler
    tick = s_q.clock_divider_sel_cnt == div_last(s_q.clock_divider_sel_sel);
    s_d.clock_divider_sel_cnt = tick ? 8'h00 : s_q.clock_divider_sel_cnt + 8'h01;
    // write channels are taken independently, then applied together
    if (axi_req.awvalid && !s_q.aw_held && !s_q.bvalid) begin
      s_d.aw_held = 1'b1;
      s_d.aw_idx = axi_req.awaddr[7:2];
    end
    if (axi_req.wvalid && !s_q.w_held && !s_q.bvalid) begin
      s_d.w_held = 1'b1;
      s_d.w_data = axi_req.wdata;
      s_d.w_strb = axi_req.wstrb;
    end
    if (s_q.aw_held && s_q.w_held && !s_q.bvalid) begin
      do_write = 1'b1;
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = idx_mapped(s_q.aw_idx) ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_q.bvalid && axi_req.bready) begin
      s_d.bvalid = 1'b0;
    end
    // reads answer one cycle after the address is taken
    if (axi_req.arvalid && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = read_word(s_q, axi_req.araddr[7:2]);
      s_d.rresp = idx_mapped(axi_req.araddr[7:2]) ? RESP_OKAY : RESP_SLVERR;
      rd_result = axi_req.araddr[7:2] == IDX_RESULT;
    end
    if (s_q.rvalid && axi_req.rready) begin
      s_d.rvalid = 1'b0;
    end
    // register writes, low byte lane then the upper lane of thresholds
    if (do_write && ws[0]) begin
      case (s_q.aw_idx)
        IDX_CONV_CTRL: begin
          s_d.enable = wd[ENABLE_BIT];
          s_d.continuous_mode_en = wd[CONTINUOUS_MODE_EN_BIT];
          if (wd[ENABLE_BIT] && !s_q.enable) begin
            s_d.init_pending = 1'b1;
          end
        end
        IDX_ACC_CTRL: s_d.acc_sel = wd[2:0];
        IDX_CLK_CTRL: begin
          s_d.clock_divider_sel_sel = wd[2:0];
          s_d.ref_sel = wd[REF_LSB +: 2];
          if (wd[REF_LSB +: 2] == REF_INTERNAL && s_q.ref_sel != REF_INTERNAL) begin
            s_d.init_pending = 1'b1;
          end
        end
        IDX_TIMING: begin
          s_d.init_sel = wd[INIT_LSB +: 3];
          s_d.vary_en = wd[VARY_BIT];
          s_d.delay = wd[3:0];
        end
        IDX_WINDOW: s_d.win_mode = wd[2:0];
        IDX_SAMPLE: s_d.sample_len = wd[4:0];
        IDX_CHANNEL: s_d.channel_sel = wd[4:0];
        IDX_COMMAND: cmd_start = wd[0];
        IDX_EVENT: s_d.event_en = wd[0];
        IDX_INT_EN: s_d.int_en = wd[1:0];
        IDX_FLAGS: s_d.flags = s_q.flags & ~wd[1:0];
        IDX_LOW_THR: s_d.low_thr[7:0] = wd[7:0];
        IDX_HIGH_THR: s_d.high_thr[7:0] = wd[7:0];
        default: s_d.acc_sel = s_d.acc_sel;
      endcase
    end
    if (do_write && ws[1] && s_q.aw_idx == IDX_LOW_THR) begin
      s_d.low_thr[15:8] = wd[15:8];
    end
    if (do_write && ws[1] && s_q.aw_idx == IDX_HIGH_THR) begin
      s_d.high_thr[15:8] = wd[15:8];
    end
    if (rd_result) begin
      s_d.flags = 2'b00;
    end
    if (s_q.wake_s2 && !s_q.wake_s3) begin
      s_d.init_pending = 1'b1;
    end
    // start sources, only from idle with the converter enabled
    ev_start = s_q.event_en && s_q.ev_s2 && !s_q.ev_s3;
    if ((cmd_start || ev_start) && s_q.enable && s_q.phase == PH_IDLE) begin
      begin_conv = 1'b1;
    end
    // sequencer, counts advance on converter ticks
    unique case (s_q.phase)
      PH_IDLE: begin
      end
      PH_INIT: begin
        if (tick) begin
          s_d.cnt = s_q.cnt - 9'h001;
          if (s_q.cnt <= 9'h001) begin
            s_d.phase = PH_SAMPLE;
            s_d.cnt = BASE_SAMPLE_TICKS + 9'(s_q.sample_len);
          end
        end
      end
      PH_SAMPLE: begin
        if (tick) begin
          s_d.cnt = s_q.cnt - 9'h001;
          if (s_q.cnt <= 9'h001) begin
            s_d.phase = PH_CONV;
            s_d.cnt = 9'(CONV_TICKS);
          end
        end
      end
      PH_CONV: begin
        if (tick && s_q.cnt <= 9'h001) begin
          sample_end = 1'b1;
          sum = s_q.acc_sum + 16'(s_q.data_s2);
          s_d.acc_sum = sum;
          s_d.samples_left = s_q.samples_left - 7'h01;
          if (s_q.vary_en) begin
            s_d.delay = s_q.delay + 4'h1;
          end
          if (s_q.samples_left == 7'h01) begin
            done = 1'b1;
            s_d.result = sum;
            s_d.flags[READY_BIT] = 1'b1;
            if (win_match(s_q.win_mode, sum, s_q.low_thr, s_q.high_thr)) begin
              s_d.flags[WINDOW_BIT] = 1'b1;
            end
            s_d.phase = PH_IDLE;
            if (s_q.continuous_mode_en) begin
              begin_conv = 1'b1;
            end
          end else if (s_q.delay != 4'h0) begin
            s_d.phase = PH_DELAY;
            s_d.cnt = 9'(s_q.delay);
          end else begin
            s_d.phase = PH_SAMPLE;
            s_d.cnt = BASE_SAMPLE_TICKS + 9'(s_q.sample_len);
          end
        end else if (tick) begin
          s_d.cnt = s_q.cnt - 9'h001;
        end
      end
      PH_DELAY: begin
        if (tick) begin
          s_d.cnt = s_q.cnt - 9'h001;
          if (s_q.cnt <= 9'h001) begin
            s_d.phase = PH_SAMPLE;
            s_d.cnt = BASE_SAMPLE_TICKS + 9'(s_q.sample_len);
          end
        end
      end
    endcase
    // a new measurement latches the channel and sample count
    if (begin_conv) begin
      s_d.active_ch = s_q.channel_sel;
      s_d.acc_sum = 16'h0000;
      s_d.samples_left = 7'h01 << ((s_q.acc_sel > ACC_LAST_CODE) ? 3'h0 : s_q.acc_sel);
      if (s_d.init_pending && init_ticks(s_q.init_sel) != 9'h000) begin
        s_d.phase = PH_INIT;
        s_d.cnt = init_ticks(s_q.init_sel);
      end else begin
        s_d.phase = PH_SAMPLE;
        s_d.cnt = BASE_SAMPLE_TICKS + 9'(s_q.sample_len);
      end
      s_d.init_pending = 1'b0;
    end
    if (!s_d.enable) begin
      s_d.phase = PH_IDLE; // disabling aborts a measurement
    end
  end

  // state register
  always_ff @(posedge clock) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // bus answers and pin outputs
  assign axi_rsp.awready = !s_q.aw_held && !s_q.bvalid;
  assign axi_rsp.wready = !s_q.w_held && !s_q.bvalid;
  assign axi_rsp.bvalid = s_q.bvalid;
  assign axi_rsp.bresp = s_q.bresp;
  assign axi_rsp.arready = !s_q.rvalid;
  assign axi_rsp.rvalid = s_q.rvalid;
  assign axi_rsp.rdata = s_q.rdata;
  assign axi_rsp.rresp = s_q.rresp;
  assign afe_channel = s_q.active_ch;
  assign afe_channel_ok = channel_legal(s_q.active_ch);
  assign afe_sample_close = s_q.phase == PH_SAMPLE;
  assign afe_convert = s_q.phase == PH_CONV;
  assign conversion_busy = s_q.phase != PH_IDLE;
  assign result_irq = s_q.flags[READY_BIT] && s_q.int_en[READY_BIT];
  assign window_irq = s_q.flags[WINDOW_BIT] && s_q.int_en[WINDOW_BIT];

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence seq_last_sample;
    s_q.phase == PH_CONV && tick && s_q.cnt <= 9'h001 && s_q.samples_left == 7'h01;
  endsequence

  sequence seq_flag_write(int b);
    s_q.aw_held && s_q.w_held && !s_q.bvalid && s_q.w_strb[0]
      && s_q.aw_idx == IDX_FLAGS && s_q.w_data[b];
  endsequence

  a_start_by_command: assert property (s_q.aw_held && s_q.w_held && !s_q.bvalid
      && s_q.w_strb[0] && s_q.aw_idx == IDX_COMMAND && s_q.w_data[0]
      && s_q.enable && s_q.phase == PH_IDLE |=> conversion_busy)
    else $error("start command did not begin a measurement");
  a_busy_until_done: assert property (seq_last_sample and !s_q.continuous_mode_en
      |=> !conversion_busy)
    else $error("busy not cleared at completion");
  a_ready_flag_set: assert property (seq_last_sample |=> s_q.flags[READY_BIT])
    else $error("ready flag missing after completion");
  a_window_end_only: assert property (!s_q.flags[WINDOW_BIT] && !done
      |=> !s_q.flags[WINDOW_BIT])
    else $error("window flag set outside conversion end");
  // a continuous restart may switch the mux at the boundary between measurements
  a_channel_held: assert property (s_q.phase != PH_IDLE && $past(s_q.phase) != PH_IDLE
      && !$past(done) |-> $stable(afe_channel))
    else $error("channel changed during a conversion");
  a_delay_wrap: assert property (sample_end && s_q.vary_en && s_q.delay == 4'hf
      && !(s_q.aw_held && s_q.w_held && !s_q.bvalid && s_q.aw_idx == IDX_TIMING)
      |=> s_q.delay == 4'h0)
    else $error("delay did not wrap to zero");
  a_flag_clear_one: assert property (seq_flag_write(READY_BIT) and !sample_end
      |=> !s_q.flags[READY_BIT])
    else $error("write one did not clear ready flag");
  a_sample_min_len: assert property ($rose(afe_sample_close)
      |-> afe_sample_close[*2])
    else $error("sampling shorter than two cycles");
  a_init_no_sample: assert property (s_q.phase == PH_INIT && !tick
      |=> !afe_sample_close)
    else $error("sampling during init delay");
  // a same-cycle disable write legally stops the restart
  a_continuous_mode_en_restart: assert property (seq_last_sample and s_q.continuous_mode_en and s_q.enable
      and !(s_q.aw_held && s_q.w_held && !s_q.bvalid && s_q.aw_idx == IDX_CONV_CTRL)
      |=> conversion_busy ##0 s_q.acc_sum == 16'h0000)
    else $error("continuous mode did not restart");
  a_irq_follows: assert property ($rose(result_irq) |-> s_q.int_en[READY_BIT]
      && s_q.flags[READY_BIT])
    else $error("result request without flag and enable");

endmodule
`default_nettype wire

// ==== acs_afe_model.sv ====
// Purpose: analog front end stand-in for the sequencer bench
// Assumes: the code depends only on the selected channel
// Notes: the data lines scramble while the core is not converting
`timescale 1ns/100ps
`default_nettype none
module acs_afe_model (
  input wire logic clock, // system clock
  input wire logic [4:0] afe_channel, // channel from the mux
  input wire logic afe_convert, // core converting
  output logic [9:0] afe_data // code to the sequencer
);
  // channel code while converting, inverted last value otherwise
  always @(posedge clock) begin
    if (afe_convert) begin
      afe_data <= {afe_channel, 5'h05};
    end else begin
      afe_data <= ~afe_data;
    end
  end
  initial afe_data = 10'h000;
endmodule
`default_nettype wire

// ==== acs_sequencer_test.sv ====
// Purpose: self-checking bench of the converter sequencer
// Assumes: prescaler code 0, one tick every two clocks
// Notes: all waits are bounded and end in the closing report
`timescale 1ns/100ps
`default_nettype none
module acs_sequencer_test;
  import acs_pkg::*;
  localparam int LIMIT = 4000;
  // register rows: index, mask of what reads back after writing 0xff
  localparam logic [5:0] RIDX [9] = '{IDX_TIMING, IDX_WINDOW, IDX_SAMPLE, IDX_CHANNEL,
    IDX_EVENT, IDX_INT_EN, IDX_FLAGS, IDX_COMMAND, 6'h07};
  localparam logic [7:0] RMASK [9] = '{8'hff, 8'h07, 8'h1f, 8'h1f, 8'h01, 8'h03, 8'h00,
    8'h00, 8'h00};
  // window rows: {match, mode, low, high} for a result of 0x065
  localparam logic [35:0] WROW [10] = '{36'h9_0066_ffff, 36'h1_0065_ffff,
    36'ha_0000_0064, 36'h2_0000_0065, 36'hb_0064_0066, 36'h3_0065_0066,
    36'hc_0066_0070, 36'h4_0060_0070, 36'h0_0066_0000, 36'h5_0066_0000};
  logic clock = 1'b0;
  logic reset = 1'b1;
  acs_axi_req_type axi_req = '0;
  acs_axi_rsp_type axi_rsp;
  logic start_event = 1'b0;
  logic deep_sleep_wake = 1'b0;
  logic [9:0] afe_data;
  logic [4:0] afe_channel;
  logic afe_sample_close, afe_convert, conversion_busy, result_irq, window_irq;
  logic afe_channel_ok;
  logic [31:0] rd;
  logic [1:0] rsp;
  int mismatches = 0;
  int checks_done = 0;
  int g, s;

  // clock at 40 MHz
  always #12.5 clock = ~clock;

  acs_sequencer dut_u (.clock(clock), .reset(reset), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .start_event(start_event), .deep_sleep_wake(deep_sleep_wake), .afe_data(afe_data),
    .afe_channel(afe_channel), .afe_channel_ok(afe_channel_ok),
    .afe_sample_close(afe_sample_close),
    .afe_convert(afe_convert), .conversion_busy(conversion_busy), .result_irq(result_irq),
    .window_irq(window_irq));
  acs_afe_model afe_u (.clock(clock), .afe_channel(afe_channel), .afe_convert(afe_convert),
    .afe_data(afe_data));

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_up;
    mismatches++;
    $display("Error wait expected answer seen timeout");
    conclude();
  endtask

  // write one word; address and data offered together, each released when taken
  task automatic wr(input logic [5:0] idx, input logic [31:0] data);
    int n;
    logic ta, tw, tb;
    n = 0;
    tb = 1'b0;
    axi_req.awaddr <= {idx, 2'b00};
    axi_req.wdata <= data;
    axi_req.wstrb <= 4'hf;
    axi_req.awvalid <= 1'b1;
    axi_req.wvalid <= 1'b1;
    axi_req.bready <= 1'b1;
    while (!tb) begin
      @(negedge clock);
      ta = axi_req.awvalid & axi_rsp.awready;
      tw = axi_req.wvalid & axi_rsp.wready;
      tb = axi_rsp.bvalid;
      rsp = axi_rsp.bresp;
      @(posedge clock);
      if (ta) axi_req.awvalid <= 1'b0;
      if (tw) axi_req.wvalid <= 1'b0;
      n++;
      if (n > 50) give_up();
    end
    axi_req.bready <= 1'b0;
    @(posedge clock);
  endtask

  // read one word into rd and rsp
  task automatic rdw(input logic [5:0] idx);
    int n;
    logic ta, tb;
    n = 0;
    tb = 1'b0;
    axi_req.araddr <= {idx, 2'b00};
    axi_req.arvalid <= 1'b1;
    axi_req.rready <= 1'b1;
    while (!tb) begin
      @(negedge clock);
      ta = axi_req.arvalid & axi_rsp.arready;
      tb = axi_rsp.rvalid;
      rd = axi_rsp.rdata;
      rsp = axi_rsp.rresp;
      @(posedge clock);
      if (ta) axi_req.arvalid <= 1'b0;
      n++;
      if (n > 50) give_up();
    end
    axi_req.rready <= 1'b0;
    @(posedge clock);
  endtask

  // wait for busy (sel 0) or result request (sel 1) to reach a level
  task automatic wait_for(input int sel, input logic lvl);
    int n;
    n = 0;
    do begin
      @(negedge clock);
      n++;
      if (n > LIMIT) give_up();
    end while ((sel == 1 ? result_irq : conversion_busy) !== lvl);
    @(posedge clock);
  endtask

  // one measurement: g cycles to sampling, s cycles of sampling
  task automatic run(output int g, output int s);
    wr(IDX_COMMAND, 32'h1);
    g = 0;
    s = 0;
    do begin
      @(negedge clock);
      g++;
      if (g > LIMIT) give_up();
    end while (afe_sample_close !== 1'b1);
    do begin
      @(negedge clock);
      s++;
    end while (afe_sample_close === 1'b1 && s < 100);
    @(posedge clock);
    rdw(IDX_COMMAND);
    check("start bit busy", 32'h1, rd);
    wait_for(0, 1'b0);
    rdw(IDX_COMMAND);
    check("start bit done", 32'h0, rd);
  endtask

  // main sequence
  initial begin
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    foreach (RIDX[i]) begin
      rdw(RIDX[i]);
      check("reset value", 32'h0, rd);
      wr(RIDX[i], 32'hff);
      check("write resp", RIDX[i] == 6'h07 ? RESP_SLVERR : RESP_OKAY, rsp);
      rdw(RIDX[i]);
      check("readback", {24'h0, RMASK[i]}, rd);
      wr(RIDX[i], 32'h0);
    end
    $display("test registers done");
    wr(IDX_TIMING, 32'h20);
    wr(IDX_SAMPLE, 32'h3);
    wr(IDX_CHANNEL, 32'h3);
    wr(IDX_INT_EN, 32'h3);
    wr(IDX_CONV_CTRL, 32'h1);
    run(g, s);
    check("init after enable", 1, g >= 24 && g <= 40);
    check("sample length", 1, s >= 9 && s <= 11);
    run(g, s);
    check("no init when running", 1, g <= 8);
    deep_sleep_wake <= 1'b1;
    repeat (4) @(posedge clock);
    deep_sleep_wake <= 1'b0;
    run(g, s);
    check("init after wake", 1, g >= 24 && g <= 40);
    $display("test init delay done");
    foreach (WROW[i]) begin
      wr(IDX_WINDOW, {29'h0, WROW[i][34:32]});
      wr(IDX_LOW_THR, {16'h0, WROW[i][31:16]});
      wr(IDX_HIGH_THR, {16'h0, WROW[i][15:0]});
      run(g, s);
      check("window request", WROW[i][35], window_irq);
      check("ready request", 1, result_irq);
      rdw(IDX_FLAGS);
      check("flags", {30'h0, WROW[i][35], 1'b1}, rd);
      rdw(IDX_RESULT);
      check("result", 32'h65, rd);
      check("irq after read", 0, {window_irq, result_irq});
    end
    $display("test window modes done");
    wr(IDX_WINDOW, 32'h1);
    wr(IDX_LOW_THR, 32'h66);
    run(g, s);
    wr(IDX_FLAGS, 32'h0);
    rdw(IDX_FLAGS);
    check("write zero keeps", 32'h3, rd);
    wr(IDX_FLAGS, 32'h1);
    rdw(IDX_FLAGS);
    check("write one clears", 32'h2, rd);
    wr(IDX_FLAGS, 32'h2);
    rdw(IDX_FLAGS);
    check("flags cleared", 32'h0, rd);
    wr(IDX_COMMAND, 32'h1);
    wr(IDX_CHANNEL, 32'h5);
    @(negedge clock);
    check("channel held", 32'h3, afe_channel);
    check("legal channel", 1, afe_channel_ok);
    @(posedge clock);
    wait_for(0, 1'b0);
    rdw(IDX_RESULT);
    check("old channel result", 32'h65, rd);
    $display("test channel change done");
    start_event <= 1'b1;
    repeat (10) @(negedge clock);
    check("event ignored", 0, conversion_busy);
    @(posedge clock);
    start_event <= 1'b0;
    wr(IDX_EVENT, 32'h1);
    start_event <= 1'b1;
    wait_for(0, 1'b1);
    check("channel taken", 32'h5, afe_channel);
    start_event <= 1'b0;
    wait_for(0, 1'b0);
    check("event result", 1, result_irq);
    wr(IDX_EVENT, 32'h0);
    $display("test event start done");
    wr(IDX_ACC_CTRL, 32'h1);
    wr(IDX_TIMING, 32'h1e);
    run(g, s);
    rdw(IDX_TIMING);
    check("delay varied and wrapped", 32'h10, rd);
    rdw(IDX_RESULT);
    check("two samples summed", 32'h14a, rd);
    wr(IDX_ACC_CTRL, 32'h0);
    wr(IDX_TIMING, 32'h0);
    $display("test variation done");
    wr(IDX_CONV_CTRL, 32'h3);
    wr(IDX_COMMAND, 32'h1);
    wait_for(1, 1'b1);
    rdw(IDX_RESULT);
    wait_for(1, 1'b1);
    rdw(IDX_COMMAND);
    check("continuous restart", 32'h1, rd);
    wr(IDX_CONV_CTRL, 32'h0);
    wait_for(0, 1'b0);
    $display("test continuous done");
    wr(IDX_CONV_CTRL, 32'h1);
    wr(IDX_CHANNEL, 32'hc);
    wr(IDX_COMMAND, 32'h1);
    check("reserved channel", 0, afe_channel_ok);
    wait_for(0, 1'b0);
    wr(IDX_CHANNEL, 32'h1b);
    wr(IDX_COMMAND, 32'h1);
    check("touch channel", 1, afe_channel_ok);
    wait_for(0, 1'b0);
    $display("test channel codes done");
    wr(IDX_TIMING, 32'h20);
    wr(IDX_CLK_CTRL, 32'h10);
    wr(IDX_CLK_CTRL, 32'h1);
    run(g, s);
    check("init after internal ref", 1, g >= 52 && g <= 72);
    check("divided sample length", 1, s >= 19 && s <= 21);
    wr(IDX_CLK_CTRL, 32'h0);
    $display("test reference and prescaler done");
    wr(IDX_COMMAND, 32'h1);
    check("busy before reset", 1, conversion_busy);
    reset <= 1'b1;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    @(negedge clock);
    check("busy after reset", 0, conversion_busy);
    @(posedge clock);
    rdw(IDX_TIMING);
    check("timing after reset", 32'h0, rd);
    $display("test reset done");
    conclude();
  end
endmodule
`default_nettype wire
